// file: rtl/rri_initializer.sv
// Register file with reset-class initialization, reached over APB
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "rri_regs.svh"

// Overview of operation
// [R01] Options register all ones except on wake
// [R02] Direction registers all ones except on wake
// [R03] Timer-2 period all ones on every event
// [R04] Core interrupt bits 7..1 cleared, bit 0 kept
// [R05] Wake keeps flags, sets wake cause flags
// [R06] Peripheral enables and flags cleared on reset
// [R07] Software keeps reserved peripheral bit 6 clear
// [R08] Timer-1 control cleared on power-on only
// [R09] Timer-2 count and control cleared on reset
// [R10] Serial control, status, address cleared on reset
// [R11] Power-on status bit cleared on power-on only
// [R12] Port D..G latches cleared on reset
// [R13] Program counter upper latch cleared on reset
// [R14] Converter controls cleared; result left alone
// [R15] Segment enable ones, prescaler cleared on reset
// [R16] LCD control cleared on reset, bit 5 zero
// [R17] LCD data bytes kept on every event, power-on included
// [R18] Capture control cleared; value bytes retained
// [R19] Interrupt wake with global enable loads vector
// [R20] Unimplemented bits always read zero
// [R21] One reset class applied per event
module rri_initializer (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Reset-cause events from the reset circuit
   input wire logic por_event,
   input wire logic pin_or_watchdog_event,
   input wire logic wake_event,
   input wire logic wake_by_interrupt,
   input wire logic [7:0] wake_core_flags,
   input wire logic [7:0] wake_periph_flags,
   // Applied class and program counter steering
   output rri_pkg::rri_class_type applied_class,
   output logic restart_at_zero,
   output logic resume_next,
   output logic resume_vector
);
   import rri_pkg::*;

   // Every check below runs on the bus clock and rests in reset
   default clocking rri_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ----------------------------------------------------------------
   // Decode functions
   // ----------------------------------------------------------------

   // Bits that exist in a register
   function automatic rri_byte_type rri_impl_mask(input rri_index_type idx);
      case (idx)
         `RRI_PC_UPPER_LATCH: rri_impl_mask = `RRI_MASK_PC_UPPER;
         `RRI_PERIPH_FLAGS, `RRI_PERIPH_ENABLES, `RRI_TIMER1_CTRL,
         `RRI_CAPCMP_CTRL, `RRI_PORT_A_DIR, `RRI_PORT_C_DIR:
            rri_impl_mask = `RRI_MASK_SIX;
         `RRI_TIMER2_CTRL: rri_impl_mask = `RRI_MASK_TIMER2_CTRL;
         `RRI_CONV_CTRL0: rri_impl_mask = `RRI_MASK_CONV_CTRL0;
         `RRI_CONV_CTRL1: rri_impl_mask = `RRI_MASK_CONV_CTRL1;
         `RRI_LCD_PRESCALER: rri_impl_mask = `RRI_MASK_LCD_PRESCALER;
         `RRI_LCD_CTRL: rri_impl_mask = `RRI_MASK_LCD_CTRL;
         `RRI_POWER_STATUS: rri_impl_mask = `RRI_MASK_POWER_STATUS;
         default: rri_impl_mask = `RRI_MASK_FULL;
      endcase
   endfunction : rri_impl_mask

   // Value loaded by an initializing event
   function automatic rri_byte_type rri_init_value(input rri_index_type idx);
      case (idx)
         `RRI_CORE_OPTIONS, `RRI_TIMER2_PERIOD, `RRI_LCD_SEG_ENABLE,
         `RRI_PORT_A_DIR, `RRI_PORT_B_DIR, `RRI_PORT_C_DIR,
         `RRI_PORT_D_DIR, `RRI_PORT_E_DIR, `RRI_PORT_F_DIR,
         `RRI_PORT_G_DIR:
            rri_init_value = `RRI_INIT_ONES & rri_impl_mask(idx);
         default: rri_init_value = `RRI_INIT_ZERO;
      endcase
   endfunction : rri_init_value

   // Bits that a given class loads; the rest are retained
   function automatic rri_byte_type rri_load_mask(input rri_index_type idx,
                                                  input rri_class_type cls);
      logic undefined;
      undefined = (idx >= `RRI_LCD_DATA_BASE)
         || (idx == `RRI_TIMER1_LOW) || (idx == `RRI_TIMER1_HIGH)
         || (idx == `RRI_SERIAL_BUFFER) || (idx == `RRI_CAPCMP_LOW)
         || (idx == `RRI_CAPCMP_HIGH) || (idx == `RRI_CONV_RESULT);
      rri_load_mask = `RRI_INIT_ZERO;
      unique case (cls)
         RRI_POR:
         begin
            if (!undefined)
               rri_load_mask = rri_impl_mask(idx);
            // [R04] Core control bit 0 kept
            if (idx == `RRI_CORE_INT_CTRL)
               rri_load_mask = `RRI_MASK_INT_CTRL_LOAD;
         end
         RRI_PIN:
         begin
            if (!undefined && idx != `RRI_TIMER1_CTRL
                && idx != `RRI_POWER_STATUS)
               rri_load_mask = rri_impl_mask(idx);
            if (idx == `RRI_CORE_INT_CTRL)
               rri_load_mask = `RRI_MASK_INT_CTRL_LOAD;
         end
         RRI_WAKE:
         begin
            if (idx == `RRI_TIMER2_PERIOD)
               rri_load_mask = `RRI_MASK_FULL;
         end
         RRI_NONE: rri_load_mask = `RRI_INIT_ZERO;
      endcase
   endfunction : rri_load_mask

   // ----------------------------------------------------------------
   // Storage and class decode
   // ----------------------------------------------------------------
   rri_byte_type regs [0:`RRI_LAST_INDEX];
   rri_class_type next_class;
   rri_index_type bus_index;
   logic bus_mapped;
   logic bus_write;
   logic gie_now;

   // Power-on outranks pin/watchdog, which outranks wake
   // [R21] Exactly one class
   always_comb
   begin
      if (por_event)
         next_class = RRI_POR;
      else if (pin_or_watchdog_event)
         next_class = RRI_PIN;
      else if (wake_event)
         next_class = RRI_WAKE;
      else
         next_class = RRI_NONE;
   end

   // Address decode; only aligned words inside the map answer cleanly
   assign bus_index = paddr[7:2];
   assign bus_mapped = (paddr[1:0] == 2'b00)
                       && (bus_index <= `RRI_LAST_INDEX);
   assign bus_write = psel && penable && pready && pwrite && bus_mapped;
   assign gie_now = regs[`RRI_CORE_INT_CTRL][`RRI_GIE_BIT];

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------

   // Init events win over a bus write landing in the same cycle,
   // since the core is held in reset or waking at that moment
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i <= int'(`RRI_LAST_INDEX); i++)
            regs[i] <= rri_init_value(6'(i));
      end
      else if (next_class != RRI_NONE)
      begin
         // [R01] [R02] [R03] [R06] class loads
         // [R08] [R09] [R10] [R11] [R12] [R13] masked per class
         // [R14] [R15] [R16] [R17] [R18] unknowns are retained
         for (int i = 0; i <= int'(`RRI_LAST_INDEX); i++)
            regs[i] <= (regs[i] & ~rri_load_mask(6'(i), next_class))
                       | (rri_init_value(6'(i))
                          & rri_load_mask(6'(i), next_class));
         // [R05] Wake cause recorded
         if (next_class == RRI_WAKE)
         begin
            regs[`RRI_CORE_INT_CTRL] <= regs[`RRI_CORE_INT_CTRL]
                                        | wake_core_flags;
            regs[`RRI_PERIPH_FLAGS] <= regs[`RRI_PERIPH_FLAGS]
               | (wake_periph_flags & rri_impl_mask(`RRI_PERIPH_FLAGS));
         end
      end
      // [R20] Unimplemented bits never stored
      else if (bus_write && bus_index != `RRI_CONV_RESULT)
         regs[bus_index] <= pwdata[7:0] & rri_impl_mask(bus_index);
   end

   // ----------------------------------------------------------------
   // APB answer: one wait state, so pready comes from a flop
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready)
         begin
            pslverr <= !bus_mapped;
            // [R20] Masked read data
            prdata <= bus_mapped
                      ? {24'h00_0000,
                         regs[bus_index] & rri_impl_mask(bus_index)}
                      : 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Program counter steering and class report
   // ----------------------------------------------------------------

   // Pulses last one cycle, one edge after the event
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         applied_class <= RRI_NONE;
         restart_at_zero <= 1'b0;
         resume_next <= 1'b0;
         resume_vector <= 1'b0;
      end
      else
      begin
         applied_class <= next_class;
         restart_at_zero <= (next_class == RRI_POR)
                            || (next_class == RRI_PIN);
         // [R19] Vector on interrupt wake
         resume_vector <= (next_class == RRI_WAKE) && wake_by_interrupt
                          && gie_now;
         resume_next <= (next_class == RRI_WAKE)
                        && !(wake_by_interrupt && gie_now);
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic [7:0] rd_mask_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rd_mask_q <= 8'h00;
      else
         rd_mask_q <= rri_impl_mask(bus_index);
   end

   // [R01] Options on reset
   options_init_a: assert property ( // [R01]
      applied_class inside {RRI_POR, RRI_PIN}
      |-> regs[`RRI_CORE_OPTIONS] == 8'hFF)
      else $error("options not all ones after reset");

   // [R01] Options kept on wake
   options_wake_a: assert property ( // [R01]
      next_class == RRI_WAKE
      |=> regs[`RRI_CORE_OPTIONS] == $past(regs[`RRI_CORE_OPTIONS]))
      else $error("options changed on wake");

   // [R02] Directions become inputs
   dir_init_a: assert property ( // [R02]
      applied_class inside {RRI_POR, RRI_PIN}
      |-> regs[`RRI_PORT_A_DIR] == 8'h3F && regs[`RRI_PORT_G_DIR] == 8'hFF)
      else $error("direction registers not inputs");

   // [R03] Period forced on wake
   period_wake_a: assert property ( // [R03]
      next_class == RRI_WAKE |=> regs[`RRI_TIMER2_PERIOD] == 8'hFF)
      else $error("timer period not forced on wake");

   // [R04] Core control on pin reset
   intctl_pin_a: assert property ( // [R04]
      next_class == RRI_PIN
      |=> regs[`RRI_CORE_INT_CTRL][7:1] == 7'h00
      && regs[`RRI_CORE_INT_CTRL][0] == $past(regs[`RRI_CORE_INT_CTRL][0]))
      else $error("interrupt control wrong after pin reset");

   // [R05] Wake cause recorded
   wake_flags_a: assert property ( // [R05]
      next_class == RRI_WAKE
      |=> (regs[`RRI_PERIPH_FLAGS] & $past(wake_periph_flags) & 8'h3F)
          == ($past(wake_periph_flags) & 8'h3F)
      && (regs[`RRI_CORE_INT_CTRL] & $past(wake_core_flags))
          == $past(wake_core_flags))
      else $error("wake cause flag lost");

   // [R06] Peripheral enables, flags cleared
   periph_clear_a: assert property ( // [R06]
      next_class inside {RRI_POR, RRI_PIN}
      |=> regs[`RRI_PERIPH_ENABLES] == 8'h00
      && regs[`RRI_PERIPH_FLAGS] == 8'h00)
      else $error("peripheral enables or flags not cleared");

   // [R08] Timer-1 control kept
   t1ctl_pin_a: assert property ( // [R08]
      next_class == RRI_PIN
      |=> $stable(regs[`RRI_TIMER1_CTRL]))
      else $error("timer1 control changed on pin reset");

   // [R09] Timer-2 cleared on reset
   timer2_clear_a: assert property ( // [R09]
      next_class inside {RRI_POR, RRI_PIN}
      |=> regs[`RRI_TIMER2_COUNT] == 8'h00
      && regs[`RRI_TIMER2_CTRL] == 8'h00)
      else $error("timer2 count or control not cleared");

   // [R10] Serial registers cleared
   serial_clear_a: assert property ( // [R10]
      next_class inside {RRI_POR, RRI_PIN}
      |=> regs[`RRI_SERIAL_CTRL] == 8'h00
      && regs[`RRI_SERIAL_STATUS] == 8'h00
      && regs[`RRI_SERIAL_ADDR] == 8'h00)
      else $error("serial registers not cleared");

   // [R11] Power-on bit cleared
   pwr_status_a: assert property ( // [R11]
      next_class == RRI_POR |=> regs[`RRI_POWER_STATUS] == 8'h00
      ##1 (next_class != RRI_POR || regs[`RRI_POWER_STATUS] == 8'h00))
      else $error("power-on status not cleared");

   // [R12] [R13] Latches cleared
   latch_clear_a: assert property ( // [R12] [R13]
      next_class inside {RRI_POR, RRI_PIN}
      |=> regs[`RRI_PORT_D_LATCH] == 8'h00
      && regs[`RRI_PORT_G_LATCH] == 8'h00
      && regs[`RRI_PC_UPPER_LATCH] == 8'h00)
      else $error("latches not cleared");

   // [R14] Converter controls cleared
   conv_clear_a: assert property ( // [R14]
      next_class inside {RRI_POR, RRI_PIN}
      |=> regs[`RRI_CONV_CTRL0] == 8'h00 && regs[`RRI_CONV_CTRL1] == 8'h00)
      else $error("converter controls not cleared");

   // [R15] [R16] LCD controls set up
   lcd_init_a: assert property ( // [R15] [R16]
      next_class inside {RRI_POR, RRI_PIN}
      |=> regs[`RRI_LCD_SEG_ENABLE] == 8'hFF
      && regs[`RRI_LCD_PRESCALER] == 8'h00
      && regs[`RRI_LCD_CTRL] == 8'h00)
      else $error("lcd controls not initialized");

   // [R17] [R18] Data bytes kept
   data_keep_a: assert property ( // [R17] [R18]
      next_class != RRI_NONE
      |=> $stable(regs[`RRI_LCD_DATA_BASE])
      && $stable(regs[`RRI_LAST_INDEX])
      && $stable(regs[`RRI_CAPCMP_LOW]) && $stable(regs[`RRI_CAPCMP_HIGH]))
      else $error("retained data bytes changed");

   // [R20] Unimplemented bits read zero
   read_zero_a: assert property ( // [R20]
      psel && penable && pready
      |-> (prdata[7:0] & ~rd_mask_q) == 8'h00 && prdata[31:8] == 24'h0)
      else $error("unimplemented bits read nonzero");

   // [R19] Vector on interrupt wake
   vector_take_a: assert property ( // [R19]
      next_class == RRI_WAKE && wake_by_interrupt && gie_now
      |=> resume_vector && !resume_next)
      else $error("interrupt vector not taken");

   // [R21] One class per event
   one_class_a: assert property ( // [R21]
      $onehot0({restart_at_zero, resume_next, resume_vector}))
      else $error("more than one class applied");

   // Answer after a single wait state
   apb_answer_a: assert property (
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer not one wait state");

   por_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
      next_class == RRI_POR);
   wake_vec_c: cover property (@(posedge pclk) disable iff (!presetn)
      resume_vector);
   bus_write_c: cover property (@(posedge pclk) disable iff (!presetn)
      bus_write ##1 next_class == RRI_PIN);
   bad_addr_c: cover property (@(posedge pclk) disable iff (!presetn)
      pready && pslverr);

endmodule : rri_initializer

// file: rtl/rri_pkg.sv
// Types shared by the register reset initializer
package rri_pkg;
   // Reset class applied in a cycle
   typedef enum logic [1:0] {
      RRI_NONE,
      RRI_POR,
      RRI_PIN,
      RRI_WAKE
   } rri_class_type;
   typedef logic [7:0] rri_byte_type;
   typedef logic [5:0] rri_index_type;
endpackage : rri_pkg

// file: rtl/rri_regs.svh
// Register indices, field masks and init values of the reset initializer
`ifndef RRI_REGS_SVH
`define RRI_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RRI_PORT_D_LATCH 6'h00
`define RRI_PORT_E_LATCH 6'h01
`define RRI_PC_UPPER_LATCH 6'h02
`define RRI_CORE_INT_CTRL 6'h03
`define RRI_PERIPH_FLAGS 6'h04
`define RRI_TIMER1_LOW 6'h05
`define RRI_TIMER1_HIGH 6'h06
`define RRI_TIMER1_CTRL 6'h07
`define RRI_TIMER2_COUNT 6'h08
`define RRI_TIMER2_CTRL 6'h09
`define RRI_SERIAL_BUFFER 6'h0A
`define RRI_SERIAL_CTRL 6'h0B
`define RRI_CAPCMP_LOW 6'h0C
`define RRI_CAPCMP_HIGH 6'h0D
`define RRI_CAPCMP_CTRL 6'h0E
`define RRI_CONV_RESULT 6'h0F
`define RRI_CONV_CTRL0 6'h10
`define RRI_CORE_OPTIONS 6'h11
`define RRI_PORT_A_DIR 6'h12
`define RRI_PORT_B_DIR 6'h13
`define RRI_PORT_C_DIR 6'h14
`define RRI_PORT_D_DIR 6'h15
`define RRI_PORT_E_DIR 6'h16
`define RRI_PERIPH_ENABLES 6'h17
`define RRI_POWER_STATUS 6'h18
`define RRI_TIMER2_PERIOD 6'h19
`define RRI_SERIAL_ADDR 6'h1A
`define RRI_SERIAL_STATUS 6'h1B
`define RRI_CONV_CTRL1 6'h1C
`define RRI_PORT_F_LATCH 6'h1D
`define RRI_PORT_G_LATCH 6'h1E
`define RRI_LCD_SEG_ENABLE 6'h1F
`define RRI_LCD_PRESCALER 6'h20
`define RRI_LCD_CTRL 6'h21
`define RRI_PORT_F_DIR 6'h22
`define RRI_PORT_G_DIR 6'h23
`define RRI_LCD_DATA_BASE 6'h24
`define RRI_LAST_INDEX 6'h33

// ----------------------------------------------------------------
// Implemented-bit masks and init values
// ----------------------------------------------------------------
`define RRI_MASK_FULL 8'hFF
`define RRI_MASK_SIX 8'h3F
`define RRI_MASK_PC_UPPER 8'h1F
`define RRI_MASK_TIMER2_CTRL 8'h7F
`define RRI_MASK_CONV_CTRL0 8'hFD
`define RRI_MASK_CONV_CTRL1 8'h07
`define RRI_MASK_LCD_PRESCALER 8'h0F
`define RRI_MASK_LCD_CTRL 8'hDF
`define RRI_MASK_POWER_STATUS 8'h02
`define RRI_MASK_INT_CTRL_LOAD 8'hFE
`define RRI_INIT_ONES 8'hFF
`define RRI_INIT_ZERO 8'h00
`define RRI_GIE_BIT 7
`define RRI_VECTOR_ADDR 13'h0004

`endif

// file: test/tb_top.sv
// Self-checking bench of the register reset initializer
`timescale 1ns/1ps
`include "rri_regs.svh"

module tb_top;
   import rri_pkg::*;
   // ---------------------------------------------------------
   // Stimulus and observation signals
   // ---------------------------------------------------------
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic por_event = 1'h0;
   logic pin_or_watchdog_event = 1'h0;
   logic wake_event = 1'h0;
   logic wake_by_interrupt = 1'h0;
   logic [7:0] wake_core_flags = 8'h00;
   logic [7:0] wake_periph_flags = 8'h00;
   rri_class_type applied_class;
   logic restart_at_zero;
   logic resume_next;
   logic resume_vector;
   logic [7:0] rd_val;
   logic err_seen;
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;

   rri_initializer i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .por_event(por_event),
      .pin_or_watchdog_event(pin_or_watchdog_event),
      .wake_event(wake_event), .wake_by_interrupt(wake_by_interrupt),
      .wake_core_flags(wake_core_flags),
      .wake_periph_flags(wake_periph_flags),
      .applied_class(applied_class), .restart_at_zero(restart_at_zero),
      .resume_next(resume_next), .resume_vector(resume_vector)
   );

   // Free-running 200 MHz clock
   initial
   begin
      forever #2.5 pclk = ~pclk;
   end

   // ---------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------
   task automatic stop_test;
      $display("Comparisons %0d, errors %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : stop_test

   task automatic chk(input string name, input logic [7:0] seen,
                      input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error: %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // One APB transfer; request held until pready is sampled high
   task automatic xfer(input logic wr, input logic [5:0] idx,
                       input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1)
         @(posedge pclk);
      rd_val = prdata[7:0];
      err_seen = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : xfer

   task automatic rc(input string name, input logic [5:0] idx,
                     input logic [7:0] exp);
      xfer(1'h0, idx, 8'h00);
      chk(name, rd_val, exp);
   endtask : rc

   // Implemented bits; the result register ignores writes
   function automatic logic [7:0] wmask(input logic [5:0] i);
      case (i)
         `RRI_PC_UPPER_LATCH: return 8'h1F;
         `RRI_TIMER2_CTRL: return 8'h7F;
         `RRI_CONV_CTRL0: return 8'hFD;
         `RRI_CONV_CTRL1: return 8'h07;
         `RRI_LCD_PRESCALER: return 8'h0F;
         `RRI_LCD_CTRL: return 8'hDF;
         `RRI_POWER_STATUS: return 8'h02;
         `RRI_CONV_RESULT: return 8'h00;
         `RRI_PERIPH_FLAGS, `RRI_PERIPH_ENABLES, `RRI_TIMER1_CTRL,
         `RRI_CAPCMP_CTRL, `RRI_PORT_A_DIR, `RRI_PORT_C_DIR: return 8'h3F;
         default: return 8'hFF;
      endcase
   endfunction : wmask

   // Value of a filled register after an event of the given class
   function automatic logic [7:0] expv(input logic [5:0] i,
                                       input logic wake, input logic por);
      logic [7:0] f;
      f = wmask(i);
      if (wake || i >= `RRI_LCD_DATA_BASE)
         return f;
      case (i)
         `RRI_CORE_OPTIONS, `RRI_PORT_A_DIR, `RRI_PORT_B_DIR,
         `RRI_PORT_C_DIR, `RRI_PORT_D_DIR, `RRI_PORT_E_DIR,
         `RRI_PORT_F_DIR, `RRI_PORT_G_DIR, `RRI_TIMER2_PERIOD,
         `RRI_LCD_SEG_ENABLE, `RRI_TIMER1_LOW, `RRI_TIMER1_HIGH,
         `RRI_SERIAL_BUFFER, `RRI_CAPCMP_LOW, `RRI_CAPCMP_HIGH,
         `RRI_CONV_RESULT: return f;
         `RRI_TIMER1_CTRL, `RRI_POWER_STATUS: return por ? 8'h00 : f;
         `RRI_CORE_INT_CTRL: return f & 8'h01;
         default: return 8'h00;
      endcase
   endfunction : expv

   // Ones everywhere, reserved peripheral bit 6 kept clear
   task automatic fill;
      for (int i = 0; i <= `RRI_LAST_INDEX; i++)
         xfer(1'h1, i[5:0], (i == 4 || i == 23) ? 8'hBF : 8'hFF);
   endtask : fill

   task automatic check_all(input logic wake, input logic por);
      for (int i = 0; i <= `RRI_LAST_INDEX; i++)
         rc($sformatf("reg_%h", i[5:0]), i[5:0], expv(i[5:0], wake, por));
   endtask : check_all

   // Pulse {power-on, pin, wake} for one edge, then look at steering
   task automatic fire(input logic [2:0] ev, input rri_class_type cls,
                       input logic [2:0] exp_p);
      @(posedge pclk);
      {por_event, pin_or_watchdog_event, wake_event} <= ev;
      @(posedge pclk);
      {por_event, pin_or_watchdog_event, wake_event} <= 3'h0;
      #1;
      chk("applied_class", {6'h00, applied_class}, {6'h00, cls});
      chk("steering", {5'h00, restart_at_zero, resume_next, resume_vector},
          {5'h00, exp_p});
   endtask : fire

   // Hang guard: everything should finish well within this
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fails++;
         stop_test();
      end
   end

   // ---------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      rc("options", `RRI_CORE_OPTIONS, 8'hFF);
      chk("mapped_err", {7'h00, err_seen}, 8'h00);
      rc("dir_a", `RRI_PORT_A_DIR, 8'h3F);
      rc("t2_period", `RRI_TIMER2_PERIOD, 8'hFF);
      // Write-back masks and the ignored result register
      fill();
      check_all(1'h1, 1'h0);
      xfer(1'h1, 6'h34, 8'hFF);
      chk("unmapped_err", {7'h00, err_seen}, 8'h01);
      // Pin or watchdog reset over filled registers, priority too
      fire(3'h2, RRI_PIN, 3'h4);
      check_all(1'h0, 1'h0);
      fill();
      fire(3'h7, RRI_POR, 3'h4);
      check_all(1'h0, 1'h1);
      // Interrupt wake with global enable set
      xfer(1'h1, `RRI_CORE_INT_CTRL, 8'h80);
      xfer(1'h1, `RRI_TIMER2_PERIOD, 8'h12);
      wake_by_interrupt <= 1'h1;
      wake_core_flags <= 8'h02;
      wake_periph_flags <= 8'h81;
      fire(3'h1, RRI_WAKE, 3'h1);
      rc("core_int", `RRI_CORE_INT_CTRL, 8'h82);
      rc("periph_flags", `RRI_PERIPH_FLAGS, 8'h01);
      rc("t2_period", `RRI_TIMER2_PERIOD, 8'hFF);
      rc("dir_a", `RRI_PORT_A_DIR, 8'h3F);
      // Watchdog wake, then interrupt wake without global enable
      wake_by_interrupt <= 1'h0;
      fire(3'h1, RRI_WAKE, 3'h2);
      xfer(1'h1, `RRI_CORE_INT_CTRL, 8'h00);
      wake_by_interrupt <= 1'h1;
      fire(3'h1, RRI_WAKE, 3'h2);
      rc("core_int", `RRI_CORE_INT_CTRL, 8'h02);
      stop_test();
   end
endmodule : tb_top
